// file: eirq_pkg.sv
// Package for the external interrupt input unit and its CPU-side partner.
// Assumes one clock at 125 MHz and a synchronous active-high reset.
package eirq_pkg;
    localparam int EIRQ_REG_W = 8;
    // Status and control register fields
    localparam int EIRQ_BIT_MODE = 0;
    localparam int EIRQ_BIT_MASK = 1;
    localparam int EIRQ_BIT_ACK = 2;
    localparam int EIRQ_BIT_FLAG = 3;
    localparam logic [7:0] EIRQ_SCR_RESET = 8'h00;
    // Register offsets seen by software on the AXI4-Lite port
    localparam logic [3:0] EIRQ_OFF_SCR = 4'h0;
    localparam logic [3:0] EIRQ_OFF_CTRL = 4'h4;
    localparam logic [3:0] EIRQ_OFF_STAT = 4'h8;
    // Control register fields
    localparam int EIRQ_CTRL_PIN_EN = 0;
    localparam int EIRQ_CTRL_BREAK_CLEAR_ENABLE = 1;
    localparam int EIRQ_CTRL_BREAK = 2;
    localparam int EIRQ_CTRL_STBY = 3;
    localparam int EIRQ_CTRL_VFETCH = 4;
    // Status register fields
    localparam int EIRQ_STAT_REQ = 0;
    localparam int EIRQ_STAT_PIN = 1;
    localparam int EIRQ_STAT_WAKE = 2;
    localparam logic [1:0] EIRQ_RESP_OKAY = 2'b00;
    localparam logic [1:0] EIRQ_RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        EIRQ_REG_IDLE = 2'b00,
        EIRQ_REG_WRITE = 2'b01,
        EIRQ_REG_READ = 2'b10
    } eirq_reg_st_t;
endpackage

// file: eirq_if.sv
// Connection between the interrupt unit and the CPU-side partner.
// Assumes the bench resolves the request pin from the enables.
`timescale 1ns/1ps
interface eirq_if;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic pullup_en;
    logic pin_function_enable;
    logic irq_req;
    logic wake_req;
    logic pin_level;
    logic vector_fetch;
    logic break_state;
    logic break_clear_enable;
    logic standby;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    modport device (
        input pin_in, pin_function_enable, vector_fetch, break_state,
        input break_clear_enable, standby, reg_wr, reg_rd, reg_wdata,
        output pin_out, pin_oe, pullup_en, irq_req, wake_req, pin_level,
        output reg_rdata
    );
    modport cpu (
        output pin_function_enable, vector_fetch, break_state,
        output break_clear_enable, standby, reg_wr, reg_rd, reg_wdata,
        input irq_req, wake_req, pin_level, reg_rdata
    );
endinterface

// file: eirq_device.sv
// Interrupt unit end: pin, latch and its status/control register.
// Assumes the partner drives register strobes one cycle each.
`timescale 1ns/1ps
module eirq_device
    import eirq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    eirq_if.device bus,
    output logic o_pending
);
    // Pin synchroniser and the level it has agreed on
    logic [2:0] sync_q;
    logic pin_prev_q;
    logic agree;
    // Request latch and the two software fields
    logic latch_q;
    logic latch_d;
    logic mode_q;
    logic mode_d;
    logic mask_q;
    logic mask_d;
    // Registered lines towards the CPU side
    logic irq_q;
    logic irq_d;
    logic wake_q;
    logic wake_d;
    logic lvl_q;
    logic pending_q;
    logic [EIRQ_REG_W-1:0] rdata_q;
    logic [EIRQ_REG_W-1:0] rdata_d;
    // Decoded conditions
    logic pin_lo;
    logic fall;
    logic hw_ack;
    logic sw_ack;
    logic clr_ok;
    logic ack;
    logic req;

    // Pin is only an input here; never driven
    assign bus.pin_out = 1'b0;
    assign bus.pin_oe = 1'b0;
    assign bus.pullup_en = 1'b1;

    // three flops without reset: a pin held low through
    // reset must not pass for a fresh edge once reset lifts
    always_ff @(posedge i_clock) begin
        sync_q <= {sync_q[1:0], bus.pin_in};
    end

    // a change counts once second and third flops agree
    assign agree = sync_q[1] == sync_q[2];

    // agreed level, the reference for edge detection
    always_ff @(posedge i_clock) begin
        if (agree) begin
            pin_prev_q <= sync_q[2];
        end
    end

    // pin only counts when function enabled
    assign pin_lo = bus.pin_function_enable && !pin_prev_q;
    // falling edge: agreed low after agreed high
    assign fall = bus.pin_function_enable && pin_prev_q && agree
        && !sync_q[2];

    assign hw_ack = bus.vector_fetch;
    // acknowledge bit in a register write
    assign sw_ack = bus.reg_wr && bus.reg_wdata[EIRQ_BIT_ACK];
    // break protects clears unless enabled
    // a clear made in break simply stays made
    assign clr_ok = !bus.break_state || bus.break_clear_enable;
    // Either acknowledge, gated by break protection
    assign ack = (hw_ack || sw_ack) && clr_ok;

    // edge beats acknowledge in one cycle, so none is lost
    // edge mode: acknowledge clears at once
    assign latch_d = fall ? 1'b1 : (ack ? 1'b0 : latch_q);

    // level mode: low pin keeps request up; pin return
    // and acknowledge retire it in either order
    assign req = latch_q || (mode_q && pin_lo);

    assign mode_d = bus.reg_wr ? bus.reg_wdata[EIRQ_BIT_MODE] : mode_q;
    assign mask_d = bus.reg_wr ? bus.reg_wdata[EIRQ_BIT_MASK] : mask_q;

    // mask withholds request from the CPU
    assign irq_d = req && !mask_q;
    // unmasked request wakes the core in standby
    assign wake_d = irq_d && bus.standby;

    // image: ack bit and upper bits read zero
    always_comb begin
        rdata_d = EIRQ_SCR_RESET;
        rdata_d[EIRQ_BIT_MODE] = mode_q;
        rdata_d[EIRQ_BIT_MASK] = mask_q;
        // flag shows request whatever the mask
        rdata_d[EIRQ_BIT_FLAG] = req;
    end

    // reset clears the latch; masked edges still fill it
    // so polling the flag works
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    // reset clears mode, dropping a level request
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mask_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // live level; reads high in reset, as the pin idles
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            lvl_q <= 1'b1;
        end else begin
            lvl_q <= pin_prev_q;
        end
    end

    // flag registered for the pending output
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= req;
        end
    end

    // register image, all zero out of reset
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rdata_q <= EIRQ_SCR_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Every line to the CPU side leaves a flop
    assign bus.irq_req = irq_q;
    assign bus.wake_req = wake_q;
    assign bus.pin_level = lvl_q;
    assign bus.reg_rdata = rdata_q;
    assign o_pending = pending_q;
endmodule

// file: eirq_cpu_side.sv
// CPU-side end: AXI4-Lite slave that drives the unit's control lines.
// Assumes a single master, one write and one read at a time.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module eirq_cpu_side
    import eirq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    eirq_if.cpu bus,
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_global_mask,
    output logic o_cpu_irq
);
    logic [3:0] awaddr_q;
    logic aw_q;
    logic [7:0] wdata_q;
    logic w_q;
    logic [4:0] ctrl_q;
    logic wr_q;
    logic vf_q;
    logic irq_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_wr;
    logic hit_scr;
    logic hit_ctrl;
    logic [31:0] rd_word;
    logic rd_ok;

    assign do_wr = aw_q && w_q && !bvalid_q;
    assign hit_scr = awaddr_q == EIRQ_OFF_SCR;
    assign hit_ctrl = awaddr_q == EIRQ_OFF_CTRL;
    assign rd_ok = (i_araddr == EIRQ_OFF_SCR) || (i_araddr == EIRQ_OFF_CTRL)
        || (i_araddr == EIRQ_OFF_STAT);
    assign rd_word = (i_araddr == EIRQ_OFF_SCR) ? {24'h0, bus.reg_rdata} :
        (i_araddr == EIRQ_OFF_CTRL) ? {27'h0, ctrl_q} :
        (i_araddr == EIRQ_OFF_STAT) ?
        {29'h0, bus.wake_req, bus.pin_level, bus.irq_req} : 32'h0;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 8'h00;
            ctrl_q <= 5'h01;
            wr_q <= 1'b0;
            vf_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= EIRQ_RESP_OKAY;
        end else begin
            wr_q <= 1'b0;
            vf_q <= 1'b0;
            if (i_awvalid && !aw_q) begin
                aw_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && !w_q) begin
                w_q <= 1'b1;
                wdata_q <= i_wstrb[0] ? i_wdata[7:0] : 8'h00;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (hit_scr || hit_ctrl) ? EIRQ_RESP_OKAY
                    : EIRQ_RESP_SLVERR;
                wr_q <= hit_scr;
                if (hit_ctrl) begin
                    ctrl_q <= {1'b0, wdata_q[3:0]};
                    // Fetch strobe is a pulse, not stored
                    vf_q <= wdata_q[EIRQ_CTRL_VFETCH];
                end
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= EIRQ_RESP_OKAY;
            irq_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else begin
            awready_q <= i_awvalid && !aw_q && !awready_q;
            wready_q <= i_wvalid && !w_q && !wready_q;
            arready_q <= i_arvalid && !rvalid_q && !arready_q;
            if (arready_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_ok ? EIRQ_RESP_OKAY : EIRQ_RESP_SLVERR;
            end else if (rvalid_q && i_rready) begin
                rvalid_q <= 1'b0;
            end
            irq_q <= bus.irq_req && !i_global_mask;
        end
    end

    assign bus.pin_function_enable = ctrl_q[EIRQ_CTRL_PIN_EN];
    assign bus.break_clear_enable = ctrl_q[EIRQ_CTRL_BREAK_CLEAR_ENABLE];
    assign bus.break_state = ctrl_q[EIRQ_CTRL_BREAK];
    assign bus.standby = ctrl_q[EIRQ_CTRL_STBY];
    assign bus.vector_fetch = vf_q;
    assign bus.reg_wr = wr_q;
    assign bus.reg_rd = arready_q;
    assign bus.reg_wdata = wdata_q;
    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_cpu_irq = irq_q;
endmodule

// file: eirq_checker.sv
// Assertions on the link between the interrupt unit and its CPU side.
// Assumes it watches the one interface instance joining the two ends.
`timescale 1ns/1ps
module eirq_checker
    import eirq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic pin_in,
    input wire logic pin_function_enable,
    input wire logic irq_req,
    input wire logic wake_req,
    input wire logic pin_level,
    input wire logic vector_fetch,
    input wire logic break_state,
    input wire logic break_clear_enable,
    input wire logic standby,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    logic mask_q;
    logic mode_q;
    logic clr_ok;
    logic ack;
    assign clr_ok = !break_state || break_clear_enable;
    assign ack = vector_fetch || reg_wr && reg_wdata[EIRQ_BIT_ACK];
    // Shadow of mask and mode, as the unit sees every register write
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mask_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (reg_wr) begin
            mask_q <= reg_wdata[EIRQ_BIT_MASK];
            mode_q <= reg_wdata[EIRQ_BIT_MODE];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_pin_level_live: assert property (
        $stable(pin_in) [*6] |-> pin_level == pin_in)
        else $error("pin level not passed on");
    a_reset_idle: assert property (
        $fell(i_sys_rst) |-> !irq_req && !wake_req)
        else $error("request left after reset");
    a_mask_holds: assert property (
        mask_q && $past(mask_q) |-> !irq_req)
        else $error("masked request reached cpu");
    a_edge_latches: assert property (
        ($fell(pin_in) && pin_function_enable && !mask_q) ##1
        (!pin_in && pin_function_enable && !mask_q && !ack) [*6]
        |-> irq_req)
        else $error("falling edge not latched");
    a_level_active: assert property (
        (mode_q && !mask_q && !pin_in && pin_function_enable) [*7]
        |-> irq_req)
        else $error("low level not requesting");
    a_ack_clears: assert property (
        (pin_in [*6] ##0 (ack && clr_ok)) ##1 pin_in [*2] |-> !irq_req)
        else $error("acknowledge did not clear");
    a_break_keeps: assert property (
        (reg_wr && reg_wdata[EIRQ_BIT_ACK] && !reg_wdata[EIRQ_BIT_MASK]
        && !clr_ok && irq_req && !vector_fetch && !$past(vector_fetch))
        ##1 !vector_fetch |-> ##1 irq_req)
        else $error("latch cleared during break");
    a_wake_standby: assert property (
        (standby && irq_req) [*3] |-> wake_req)
        else $error("no wake in standby");
    a_reg_zeros: assert property (
        reg_rdata[7:4] == 4'h0 && !reg_rdata[EIRQ_BIT_ACK])
        else $error("unused status bits not zero");
endmodule

// file: tb_top.sv
// Bench joining the interrupt unit and its CPU side over their interface.
// Assumes the CPU side decodes offsets 0x0, 0x4 and 0x8 on AXI4-Lite.
`timescale 1ns/1ps
module tb_top;
    import eirq_pkg::*;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic gmask = 1'b0;
    logic pin_low = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cpu_irq, pending;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    eirq_if ifc ();
    // Pullup wins unless the bench pulls the pin low
    assign ifc.pin_in = !pin_low && (ifc.pin_oe ? ifc.pin_out : ifc.pullup_en);
    eirq_device eirq_device_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .bus(ifc.device), .o_pending(pending));
    eirq_cpu_side eirq_cpu_side_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .bus(ifc.cpu), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_global_mask(gmask), .o_cpu_irq(cpu_irq));
    eirq_checker eirq_checker_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .pin_in(ifc.pin_in),
        .pin_function_enable(ifc.pin_function_enable),
        .irq_req(ifc.irq_req), .wake_req(ifc.wake_req),
        .pin_level(ifc.pin_level), .vector_fetch(ifc.vector_fetch),
        .break_state(ifc.break_state),
        .break_clear_enable(ifc.break_clear_enable),
        .standby(ifc.standby), .reg_wr(ifc.reg_wr),
        .reg_wdata(ifc.reg_wdata), .reg_rdata(ifc.reg_rdata));
    always #4 i_clock = ~i_clock;
    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A run of a few hundred cycles; a hang ends here
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rsp(input logic [3:0] a);
        return {30'h0, a > EIRQ_OFF_STAT ? EIRQ_RESP_SLVERR : EIRQ_RESP_OKAY};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, rsp(a));
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({30'h0, rresp}, rsp(a));
        if (a <= EIRQ_OFF_STAT) chk(rdata, exp);
    endtask
    // Fixed settle time covers the pin synchroniser and the latch
    task automatic pin(input logic low);
        pin_low <= low;
        repeat (8) @(posedge i_clock);
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd(EIRQ_OFF_SCR, 32'h00);
        rd(EIRQ_OFF_CTRL, 32'h01);
        rd(EIRQ_OFF_STAT, 32'h02);
        rd(4'hc, 32'h00);
        wr(4'hc, 8'h00);
        pin(1'b1);
        rd(EIRQ_OFF_SCR, 32'h08);
        chk({31'h0, pending}, 32'h1);
        chk({31'h0, cpu_irq}, 32'h1);
        gmask <= 1'b1;
        pin(1'b1);
        chk({31'h0, cpu_irq}, 32'h0);
        gmask <= 1'b0;
        wr(EIRQ_OFF_SCR, 8'h04);
        rd(EIRQ_OFF_SCR, 32'h00);
        pin(1'b0);
        pin(1'b1);
        rd(EIRQ_OFF_SCR, 32'h08);
        wr(EIRQ_OFF_CTRL, 8'h11);
        rd(EIRQ_OFF_SCR, 32'h00);
        pin(1'b0);
        wr(EIRQ_OFF_SCR, 8'h02);
        pin(1'b1);
        rd(EIRQ_OFF_SCR, 32'h0a);
        chk({31'h0, cpu_irq}, 32'h0);
        wr(EIRQ_OFF_SCR, 8'h06);
        rd(EIRQ_OFF_SCR, 32'h02);
        pin(1'b0);
        wr(EIRQ_OFF_SCR, 8'h01);
        pin(1'b1);
        wr(EIRQ_OFF_SCR, 8'h05);
        rd(EIRQ_OFF_SCR, 32'h09);
        wr(EIRQ_OFF_SCR, 8'h03);
        rd(EIRQ_OFF_SCR, 32'h0b);
        chk({31'h0, cpu_irq}, 32'h0);
        wr(EIRQ_OFF_SCR, 8'h01);
        pin(1'b0);
        rd(EIRQ_OFF_SCR, 32'h01);
        pin(1'b1);
        pin(1'b0);
        rd(EIRQ_OFF_SCR, 32'h09);
        wr(EIRQ_OFF_SCR, 8'h05);
        rd(EIRQ_OFF_SCR, 32'h01);
        pin(1'b1);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        pin(1'b1);
        rd(EIRQ_OFF_SCR, 32'h00);
        pin(1'b0);
        wr(EIRQ_OFF_CTRL, 8'h05);
        pin(1'b1);
        wr(EIRQ_OFF_SCR, 8'h04);
        rd(EIRQ_OFF_SCR, 32'h08);
        wr(EIRQ_OFF_CTRL, 8'h07);
        wr(EIRQ_OFF_SCR, 8'h04);
        wr(EIRQ_OFF_CTRL, 8'h01);
        rd(EIRQ_OFF_SCR, 32'h00);
        pin(1'b0);
        wr(EIRQ_OFF_CTRL, 8'h09);
        pin(1'b1);
        rd(EIRQ_OFF_STAT, 32'h05);
        wr(EIRQ_OFF_SCR, 8'h04);
        pin(1'b0);
        wr(EIRQ_OFF_CTRL, 8'h00);
        pin(1'b1);
        rd(EIRQ_OFF_SCR, 32'h00);
        complete_run();
    end
endmodule
